// *** design/aws_params.svh ***
// Notes on behaviour
// [RQ1] Limit bits 7:0 live at 1Eh
// [RQ2] Limit bits 11:8 in 1Fh low nibble
// [RQ3] Count idle periods; sleep once limit reached
// [RQ4] Zero limit disables automatic switching
// [RQ5] Period is wake output period, or flexible
// [RQ6] Period doubles per rate step, 0.3125-1280 ms
// [RQ7] Wake uses active power, rate, decimation, idle
// [RQ8] Sleep uses rest power, rate, decimation, idle
// [RQ9] Software picks monitoring detectors via config
// [RQ10] Same detectors wake, except buffer flag
// [RQ11] Buffer flag delays sleep, never wakes
// [RQ12] Enabled detection event wakes at once
// [RQ13] Flag table: threshold/orientation restart and wake
// [RQ14] Keeps-awake set: buffer clear restarts timer
// [RQ15] Keeps-awake clear: watermark/overflow ignored
// [RQ16] Power field 1x selects flexible mode
// [RQ17] Idle time counts 312.5 us per step
// [RQ18] Count clears on wake entry and restart
// [RQ19] Both limit registers reset to zero
`ifndef AWS_PARAMS_SVH
`define AWS_PARAMS_SVH

`define AWS_OFF_LIMIT_LOW   8'h1e
`define AWS_OFF_LIMIT_HIGH  8'h1f
`define AWS_LIMIT_RESET     8'h00
`define AWS_HIGH_NIBBLE_MSB 3
`define AWS_FLEX_BIT        1
`define AWS_RATE_SLOWEST    4'hc
`define AWS_CLK_PERIOD_PS   100000
`define AWS_STEP_TIME_PS    312500000
`define AWS_STEP_CYCLES     ((`AWS_STEP_TIME_PS + `AWS_CLK_PERIOD_PS - 1) / `AWS_CLK_PERIOD_PS)

`endif

// *** design/aws_pkg.sv ***
package aws_pkg;

    // Operating state, one-hot
    typedef enum logic [1:0] {
        AWS_WAKE  = 2'b01,
        AWS_SLEEP = 2'b10
    } aws_state_t;

    // Settings of one power mode
    typedef struct packed {
        logic [1:0]  power_select;  // Power mode, 1x is flexible
        logic [3:0]  rate_select;   // Output rate code, 0 fastest
        logic [3:0]  decimation;    // Flexible measurement length
        logic [11:0] idle_time;     // Flexible idle steps
    } aws_mode_cfg_t;

    // Event source flags, active high levels
    typedef struct packed {
        logic sample_ready_flag;
        logic overrun_flag;
        logic buffer_event_flag;
        logic outside_threshold_flag;
        logic within_threshold_flag;
        logic orientation_flag;
        logic auto_sleep_flag;
        logic boot_done_flag;
    } aws_flags_t;

    // Detector selection from sensor_config_four and buffer_config_two
    typedef struct packed {
        logic outside_threshold_en;
        logic within_threshold_en;
        logic orientation_en;
        logic buffer_en;
    } aws_enables_t;

endpackage

// *** design/aws_period_gen.sv ***
`timescale 1ns/10ps
`default_nettype none
`include "aws_params.svh"
module aws_period_gen #(
    parameter int STEP_CYCLES = `AWS_STEP_CYCLES
) (
    input  wire logic                   mclk,        // System clock
    input  wire logic                   rst_n,       // Synchronised reset
    input  wire logic                   restart,     // Realign period
    input  wire aws_pkg::aws_mode_cfg_t cfg,         // Active mode settings
    output logic                        period_tick  // One pulse per period
);
    import aws_pkg::*;

    logic [11:0] step_cnt;        // Cycles within a 312.5 us step
    logic [15:0] per_cnt;         // Steps within a period
    logic [11:0] next_step_cnt;
    logic [15:0] next_per_cnt;
    logic        next_period_tick;
    logic        step_tick;       // Step boundary

    // Period length in 312.5 us steps
    function automatic logic [15:0] period_steps(input aws_mode_cfg_t c);
        logic [3:0] r;
        r = (c.rate_select > `AWS_RATE_SLOWEST) ? `AWS_RATE_SLOWEST : c.rate_select;
        if (c.power_select[`AWS_FLEX_BIT]) begin // RQ16
            // Measurement plus idle time
            period_steps = (16'h0001 << c.decimation[3:0]) + {4'h0, c.idle_time}; // RQ17
        end else begin
            // Output period doubles per slower code
            period_steps = 16'h0001 << r; // RQ6
        end
    endfunction

    // Divider and period counter
    always_comb begin
        step_tick        = (step_cnt == 12'(STEP_CYCLES - 1));
        next_step_cnt    = step_tick ? 12'h000 : step_cnt + 12'h001;
        next_per_cnt     = per_cnt;
        next_period_tick = 1'b0;
        if (step_tick) begin
            if (per_cnt >= period_steps(cfg) - 16'h0001) begin // RQ5
                next_per_cnt     = 16'h0000;
                next_period_tick = 1'b1;
            end else begin
                next_per_cnt = per_cnt + 16'h0001;
            end
        end
        if (restart) begin
            // Start a fresh period
            next_step_cnt    = 12'h000;
            next_per_cnt     = 16'h0000;
            next_period_tick = 1'b0;
        end
    end

    // Register counters
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            step_cnt    <= 12'h000;
            per_cnt     <= 16'h0000;
            period_tick <= 1'b0;
        end else begin
            step_cnt    <= next_step_cnt;
            per_cnt     <= next_per_cnt;
            period_tick <= next_period_tick;
        end
    end

endmodule
`default_nettype wire

// *** design/aws_inactivity_timer.sv ***
`timescale 1ns/10ps
`default_nettype none
`include "aws_params.svh"
module aws_inactivity_timer #(
    parameter int STEP_CYCLES = `AWS_STEP_CYCLES,
    parameter int LIMIT_W     = 12
) (
    input  wire logic                   mclk,             // 10 MHz clock
    input  wire logic                   rst_b,            // Async reset, low
    input  wire logic [7:0]             reg_addr,         // Register offset
    input  wire logic [7:0]             reg_wdata,        // Write data
    input  wire logic                   reg_we,           // Write strobe
    input  wire logic                   reg_re,           // Read strobe
    output logic      [7:0]             reg_rdata,        // Read data
    input  wire aws_pkg::aws_mode_cfg_t active_cfg,       // Wake settings
    input  wire aws_pkg::aws_mode_cfg_t rest_cfg,         // Sleep settings
    input  wire aws_pkg::aws_flags_t    flags,            // Event flags
    input  wire aws_pkg::aws_enables_t  enables,          // Monitored detectors
    input  wire logic                   buffer_keeps_awake, // Buffer clear holds wake
    input  wire logic                   buffer_flag_clear,  // Software cleared flag
    output logic                        sleep_mode,       // High in sleep
    output aws_pkg::aws_mode_cfg_t      current_cfg,      // Settings in force
    output logic                        auto_sleep_pulse, // Sleep entry pulse
    output logic      [LIMIT_W-1:0]     inactivity_count  // Idle periods counted
);
    import aws_pkg::*;

    logic                rst_meta;          // Reset sync first stage
    logic                rst_n;             // Synchronised reset
    logic [7:0]          limit_low;         // Limit bits 7:0
    logic [3:0]          limit_high;        // Limit bits 11:8
    logic [7:0]          next_limit_low;
    logic [3:0]          next_limit_high;
    logic [7:0]          next_reg_rdata;
    aws_state_t          state;             // Operating state
    aws_state_t          next_state;
    logic [LIMIT_W-1:0]  next_count;
    logic                next_auto_sleep;
    aws_mode_cfg_t       next_current_cfg;
    logic [LIMIT_W-1:0]  limit;             // Full limit value
    logic                wake_evt;          // Enabled wake source active
    logic                restart_evt;       // Timer restart source
    logic                period_restart;    // Realign period generator
    logic                period_tick;       // One counter period passed

    // Reset release through two flops
    always_ff @(posedge mclk or negedge rst_b) begin
        if (!rst_b) begin
            rst_meta <= 1'b0;
            rst_n    <= 1'b0;
        end else begin
            rst_meta <= 1'b1;
            rst_n    <= rst_meta;
        end
    end

    // Register writes
    always_comb begin
        next_limit_low  = limit_low;
        next_limit_high = limit_high;
        if (reg_we && reg_addr == `AWS_OFF_LIMIT_LOW) begin
            next_limit_low = reg_wdata; // RQ1
        end
        if (reg_we && reg_addr == `AWS_OFF_LIMIT_HIGH) begin
            // Upper nibble unused
            next_limit_high = reg_wdata[`AWS_HIGH_NIBBLE_MSB:0]; // RQ2
        end
    end

    // Register reads, unmapped reads zero
    always_comb begin
        next_reg_rdata = reg_rdata;
        if (reg_re) begin
            case (reg_addr)
                `AWS_OFF_LIMIT_LOW:  next_reg_rdata = limit_low; // RQ1
                `AWS_OFF_LIMIT_HIGH: next_reg_rdata = {4'h0, limit_high}; // RQ2
                default:             next_reg_rdata = 8'h00;
            endcase
        end
    end

    // Register storage
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            limit_low  <= `AWS_LIMIT_RESET; // RQ19
            limit_high <= 4'(`AWS_LIMIT_RESET); // RQ19
            reg_rdata  <= 8'h00;
        end else begin
            limit_low  <= next_limit_low;
            limit_high <= next_limit_high;
            reg_rdata  <= next_reg_rdata;
        end
    end

    // Event qualification
    always_comb begin
        limit = LIMIT_W'({limit_high, limit_low});
        // Only threshold and orientation flags may wake
        wake_evt = (flags.outside_threshold_flag && enables.outside_threshold_en)
                 | (flags.within_threshold_flag && enables.within_threshold_en)
                 | (flags.orientation_flag && enables.orientation_en); // RQ10 RQ13
        // Buffer clear counts only while keeps-awake is set
        // Buffer flag restarts only; watermark/overflow never enter here
        restart_evt = wake_evt
                    | (flags.buffer_event_flag && enables.buffer_en)
                    | (buffer_flag_clear && buffer_keeps_awake); // RQ11 RQ14 RQ15
    end

    // Next state and count
    always_comb begin
        next_state      = state;
        next_count      = inactivity_count;
        next_auto_sleep = 1'b0;
        period_restart  = 1'b0;
        case (state)
            AWS_WAKE: begin
                if (limit == '0) begin
                    // Automatic switching off
                    next_count     = '0; // RQ4
                    period_restart = 1'b1;
                end else if (restart_evt) begin
                    next_count     = '0; // RQ18 RQ13
                    period_restart = 1'b1;
                end else if (period_tick) begin
                    if (inactivity_count + 1'b1 >= limit) begin
                        // Limit reached
                        next_state      = AWS_SLEEP; // RQ3
                        next_count      = '0;
                        next_auto_sleep = 1'b1;
                    end else begin
                        // One more idle period
                        next_count = inactivity_count + 1'b1; // RQ3
                    end
                end
            end
            AWS_SLEEP: begin
                if (wake_evt || limit == '0) begin
                    // Wake at once, no count
                    next_state     = AWS_WAKE; // RQ12 RQ4
                    next_count     = '0; // RQ18
                    period_restart = 1'b1;
                end
            end
            default: begin
                // Stray code, recover to wake
                next_state     = AWS_WAKE;
                next_count     = '0;
                period_restart = 1'b1;
            end
        endcase
        // Settings in force follow the state
        next_current_cfg = (state == AWS_SLEEP) ? rest_cfg : active_cfg; // RQ7 RQ8
    end

    // State registers
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            state            <= AWS_WAKE;
            inactivity_count <= '0;
            auto_sleep_pulse <= 1'b0;
            sleep_mode       <= 1'b0;
            current_cfg      <= '0;
        end else begin
            state            <= next_state;
            inactivity_count <= next_count;
            auto_sleep_pulse <= next_auto_sleep;
            // Sleep flag mirrors the state register
            sleep_mode       <= (next_state == AWS_SLEEP);
            current_cfg      <= next_current_cfg;
        end
    end

    // Counter period from wake settings
    aws_period_gen #(
        .STEP_CYCLES (STEP_CYCLES)
    ) u_period (
        .mclk        (mclk),
        .rst_n       (rst_n),
        .restart     (period_restart),
        .cfg         (active_cfg),
        .period_tick (period_tick)
    );

    // Checks run on the system clock and rest during reset
    default clocking cb @(posedge mclk);
    endclocking
    default disable iff (!rst_n);

    // Steps of the sleep entry
    sequence seq_last_period;
        state == AWS_WAKE && limit != '0 && !restart_evt && period_tick
            && inactivity_count + 1'b1 >= limit;
    endsequence
    sequence seq_entered_sleep;
        sleep_mode && auto_sleep_pulse ##1 !auto_sleep_pulse;
    endsequence

    // Register port, sleep entry, wake and settings checks
    chk_limit_low_write: assert property ( // RQ1
        reg_we && reg_addr == `AWS_OFF_LIMIT_LOW |=> limit_low == $past(reg_wdata))
        else $error("limit low write not stored");

    chk_high_nibble_write: assert property ( // RQ2
        reg_we && reg_addr == `AWS_OFF_LIMIT_HIGH
        |=> limit_high == 4'($past(reg_wdata)))
        else $error("limit high nibble not stored");

    chk_high_nibble_only: assert property ( // RQ2
        reg_re && reg_addr == `AWS_OFF_LIMIT_HIGH |=> reg_rdata[7:4] == 4'h0
        && reg_rdata[3:0] == $past(limit_high))
        else $error("limit high upper bits not zero");

    chk_unmapped_zero: assert property ( // RQ1 RQ2
        reg_re && reg_addr != `AWS_OFF_LIMIT_LOW && reg_addr != `AWS_OFF_LIMIT_HIGH
        |=> reg_rdata == 8'h00)
        else $error("unmapped read not zero");

    chk_rdata_holds: assert property ( // RQ1 RQ2
        !reg_re |=> $stable(reg_rdata))
        else $error("read data changed without a read");

    chk_zero_limit_awake: assert property ( // RQ4
        limit == '0 |=> !sleep_mode && inactivity_count == '0)
        else $error("sleep with zero limit");

    chk_sleep_entry_count: assert property ( // RQ3
        seq_last_period |=> seq_entered_sleep)
        else $error("sleep not entered at limit");

    chk_no_early_sleep: assert property ( // RQ3
        $rose(sleep_mode) |-> $past(inactivity_count) + 1'b1 >= $past(limit))
        else $error("sleep entered before limit");

    chk_wake_immediate: assert property ( // RQ12
        state == AWS_SLEEP && wake_evt |=> !sleep_mode && inactivity_count == '0)
        else $error("enabled event did not wake");

    chk_buffer_no_wake: assert property ( // RQ11
        state == AWS_SLEEP && !wake_evt && limit != '0 |=> sleep_mode)
        else $error("woken without enabled detector");

    chk_restart_clears: assert property ( // RQ18
        state == AWS_WAKE && restart_evt |=> inactivity_count == '0 && !sleep_mode)
        else $error("restart did not clear count");

    chk_clear_holds_off: assert property ( // RQ14
        state == AWS_WAKE && buffer_keeps_awake && buffer_flag_clear
        |=> !sleep_mode ##1 !sleep_mode)
        else $error("buffer clear did not hold off sleep");

    chk_mode_select: assert property ( // RQ7 RQ8
        ##1 1'b1 |-> current_cfg == ($past(state) == AWS_SLEEP ? $past(rest_cfg)
                                                               : $past(active_cfg)))
        else $error("settings do not follow state");

    // Timer and event checks
    chk_pulse_one_cycle: assert property ( // RQ3
        auto_sleep_pulse |=> !auto_sleep_pulse)
        else $error("sleep entry pulse longer than one cycle");

    chk_pulse_with_rise: assert property ( // RQ3
        auto_sleep_pulse |-> $rose(sleep_mode))
        else $error("sleep entry pulse without sleep entry");

    chk_count_step: assert property ( // RQ3
        state == AWS_WAKE && limit != '0 && !restart_evt && period_tick
            && inactivity_count + 1'b1 < limit
            |=> inactivity_count == $past(inactivity_count) + 1'b1 && !sleep_mode)
        else $error("count did not advance on a period");

    chk_count_holds: assert property ( // RQ13 RQ15
        state == AWS_WAKE && limit != '0 && !period_tick
            && !(flags.outside_threshold_flag && enables.outside_threshold_en)
            && !(flags.within_threshold_flag && enables.within_threshold_en)
            && !(flags.orientation_flag && enables.orientation_en)
            && !(flags.buffer_event_flag && enables.buffer_en)
            && !(buffer_flag_clear && buffer_keeps_awake)
            |=> inactivity_count == $past(inactivity_count))
        else $error("count moved without a period or restart");

    chk_buffer_restart: assert property ( // RQ11 RQ13
        state == AWS_WAKE && flags.buffer_event_flag && enables.buffer_en
        |=> inactivity_count == '0 && !sleep_mode)
        else $error("buffer flag did not restart timer");

    chk_ignored_no_wake: assert property ( // RQ10 RQ13
        state == AWS_SLEEP && limit != '0
            && !(flags.outside_threshold_flag && enables.outside_threshold_en)
            && !(flags.within_threshold_flag && enables.within_threshold_en)
            && !(flags.orientation_flag && enables.orientation_en)
            |=> sleep_mode)
        else $error("woken by an ignored flag");

    chk_wake_entry_count: assert property ( // RQ18
        $fell(sleep_mode) |-> inactivity_count == '0)
        else $error("count not cleared on wake entry");

    chk_rest_settings: assert property ( // RQ8
        $past(sleep_mode) |-> current_cfg == $past(rest_cfg))
        else $error("sleep settings not in force");

endmodule
`default_nettype wire

// *** verification/aws_inactivity_timer_tb.sv ***
`timescale 1ns/10ps
`default_nettype none
module aws_inactivity_timer_tb;
    import aws_pkg::*;
    localparam int STEP = 4;                 // Shortened step for simulation
    logic          mclk         = 1'b0;      // System clock
    logic          rst_b        = 1'b0;      // Reset, active low
    logic [7:0]    reg_addr     = 8'h00;     // Register offset
    logic [7:0]    reg_wdata    = 8'h00;     // Write data
    logic          reg_we       = 1'b0;      // Write strobe
    logic          reg_re       = 1'b0;      // Read strobe
    logic [7:0]    reg_rdata;                // Read data
    aws_mode_cfg_t active_cfg   = '0;        // Wake settings
    aws_mode_cfg_t rest_cfg     = '0;        // Sleep settings
    aws_flags_t    flags        = '0;        // Event flags
    aws_enables_t  enables      = '1;        // Monitored detectors
    logic          keeps_awake  = 1'b0;      // Buffer clear holds wake
    logic          flag_clear   = 1'b0;      // Buffer flag cleared
    logic          sleep_mode;               // High in sleep
    aws_mode_cfg_t current_cfg;              // Settings in force
    logic          auto_sleep_pulse;         // Sleep entry pulse
    logic [11:0]   inactivity_count;         // Idle periods counted
    int            num_errors   = 0;         // Mismatches seen
    int            n_checks     = 0;         // Comparisons made
    int            lo_model     = 0;         // Model of limit low byte
    int            hi_model     = 0;         // Model of limit high nibble
    int            n;                        // Measured cycles
    logic [7:0]    v;                        // Read back value

    // Free running clock, 100 ns period
    always #50 mclk = ~mclk;

    aws_inactivity_timer #(.STEP_CYCLES(STEP)) aws_inactivity_timer_inst (
        .mclk(mclk), .rst_b(rst_b), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
        .reg_we(reg_we), .reg_re(reg_re), .reg_rdata(reg_rdata),
        .active_cfg(active_cfg), .rest_cfg(rest_cfg), .flags(flags), .enables(enables),
        .buffer_keeps_awake(keeps_awake), .buffer_flag_clear(flag_clear),
        .sleep_mode(sleep_mode), .current_cfg(current_cfg),
        .auto_sleep_pulse(auto_sleep_pulse), .inactivity_count(inactivity_count));

    // Value comparison
    task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
        n_checks++;
        if (got !== exp) begin
            num_errors++;
            $display("[ERR] %s expected %0h seen %0h", what, exp, got);
        end
    endtask

    // Settings comparison
    task automatic chk_cfg(input string what, input aws_mode_cfg_t exp, input aws_mode_cfg_t got);
        n_checks++;
        if (got !== exp) begin
            num_errors++;
            $display("[ERR] %s expected %0h seen %0h", what, exp, got);
        end
    endtask

    // Wait k edges, then step just past the edge
    task automatic tick(input int k);
        repeat (k) @(posedge mclk);
        #1;
    endtask

    // Register write, model follows the byte layout
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        reg_addr = a;
        reg_wdata = d;
        reg_we = 1'b1;
        tick(1);
        reg_we = 1'b0;
        tick(1);
        if (a == 8'h1e) lo_model = d;
        if (a == 8'h1f) hi_model = d & 8'h0f;
    endtask

    // Register read, data taken after it has settled
    task automatic rd(input logic [7:0] a, output logic [7:0] d);
        reg_addr = a;
        reg_re = 1'b1;
        tick(1);
        reg_re = 1'b0;
        tick(1);
        d = reg_rdata;
    endtask

    // Expected counter period in clock cycles
    function automatic int per_cycles(input aws_mode_cfg_t c);
        if (c.power_select[1]) return ((1 << c.decimation) + c.idle_time) * STEP;
        return (1 << ((c.rate_select > 12) ? 12 : c.rate_select)) * STEP;
    endfunction

    // Restart by a short orientation event, then time the way to sleep
    task automatic sleep_time(output int cyc);
        int exp;
        int per;
        per = per_cycles(active_cfg);
        exp = (hi_model * 256 + lo_model) * per;
        flags.orientation_flag = 1'b1;
        tick(1);
        flags.orientation_flag = 1'b0;
        cyc = 0;
        while (sleep_mode !== 1'b1 && cyc < 55000) begin
            tick(1);
            cyc++;
            if (cyc == 3) chk_cfg("wake settings", active_cfg, current_cfg);
            if (cyc == per + 1) chk("count after one period", 1, inactivity_count);
        end
        // Sleep shows one edge after the last period closes
        chk("cycles to sleep", exp + 1, cyc);
        chk("sleep entry pulse", 1, auto_sleep_pulse);
        tick(1);
        chk("pulse after one cycle", 0, auto_sleep_pulse);
        chk_cfg("sleep settings", rest_cfg, current_cfg);
    endtask

    // Verdict and end of run
    task automatic tally_and_finish;
        $display("checks %0d mismatches %0d", n_checks, num_errors);
        if (num_errors == 0 && n_checks > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask

    // Watchdog against a hang
    initial begin
        repeat (70000) @(posedge mclk);
        num_errors++;
        $display("[ERR] run length expected finish seen timeout");
        tally_and_finish();
    end

    // Main sequence
    initial begin
        void'($urandom(32'h7f21b2f1));
        tick(5);
        rst_b = 1'b1;
        tick(3);
        rd(8'h1e, v); chk("limit low reset", 8'h00, v);
        rd(8'h1f, v); chk("limit high reset", 8'h00, v);
        rd(8'h20, v); chk("unmapped read", 8'h00, v);
        $display("test reset values done");
        wr(8'h1e, 8'($urandom));
        wr(8'h1f, 8'hf0 | 8'($urandom % 16));
        rd(8'h1e, v); chk("limit low", lo_model, v);
        rd(8'h1f, v); chk("limit high", hi_model, v);
        $display("test register access done");
        wr(8'h1e, 8'h00);
        wr(8'h1f, 8'h00);
        tick(400);
        chk("sleep with zero limit", 0, sleep_mode);
        chk("count with zero limit", 0, inactivity_count);
        $display("test zero limit done");
        wr(8'h1e, 8'h03);
        rest_cfg = aws_mode_cfg_t'(22'($urandom));
        for (int r = 0; r < 5; r++) begin
            active_cfg = '0;
            // Codes above the slowest rate clamp to it
            active_cfg.rate_select = (r == 4) ? 4'hf : 4'(r);
            if (r == 1) active_cfg.power_select = 2'b01;
            if (r == 3) begin
                active_cfg.power_select = 2'b11;
                active_cfg.decimation = 4'h1;
                active_cfg.idle_time = 12'h002;
            end
            sleep_time(n);
        end
        active_cfg = '0;
        $display("test sleep timing done");
        enables = 4'b0111;
        flags = 8'hf3;
        tick(20);
        chk("sleep under ignored flags", 1, sleep_mode);
        flags = '0;
        enables = '1;
        for (int k = 0; k < 3; k++) begin
            flags = 8'h10 >> k;
            tick(1);
            chk("sleep after wake event", 0, sleep_mode);
            flags = 8'hc3;
            sleep_time(n);
        end
        $display("test wake events done");
        flags = 8'h04;
        tick(1);
        flags = 8'h20;
        tick(100);
        chk("sleep under buffer flag", 0, sleep_mode);
        chk("count under buffer flag", 0, inactivity_count);
        flags = '0;
        keeps_awake = 1'b1;
        repeat (10) begin
            flag_clear = 1'b1;
            tick(1);
            flag_clear = 1'b0;
            tick(7);
        end
        chk("sleep with keeps awake", 0, sleep_mode);
        keeps_awake = 1'b0;
        repeat (10) begin
            flag_clear = 1'b1;
            tick(1);
            flag_clear = 1'b0;
            tick(7);
        end
        chk("sleep without keeps awake", 1, sleep_mode);
        $display("test buffer flag done");
        tally_and_finish();
    end
endmodule
`default_nettype wire
